// *** design/stereo_four_tap_delay.sv ***
/*
  Stereo four tap delay: output FIFO module and the processing top with its
  APB register slave.
  Assumes a single clock pclk, an upstream source and downstream sink that use
  valid/ready, and software that programs linear gain and filter codes.
*/
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module delay_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  logic [WIDTH-1:0] store [DEPTH];  // Word storage
  logic [PW-1:0] wr_ptr;            // Next slot to fill
  logic [PW-1:0] rd_ptr;            // Oldest word
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("delay_fifo needs DEPTH of at least 2");
    end
  end

  // Honest flags straight from the occupancy count
  assign in_ready = (count != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[rd_ptr];

  // ----------------------------------------------------------------
  // Pointers and count
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

module stereo_four_tap_delay
  import stereo_four_tap_delay_pkg::*;
#(
  parameter int MAX_DELAY = MAX_DELAY_SAMPLES,  // Cap in samples
  parameter int LINE_DEPTH = MAX_DELAY_SAMPLES + 1,  // Delay memory words
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire stereo_four_tap_delay_pkg::stereo_type in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output stereo_four_tap_delay_pkg::stereo_type out_sample
);
  import stereo_four_tap_delay_pkg::*;

  localparam int AW = $clog2(LINE_DEPTH);
  localparam int FCW = $clog2(FIFO_DEPTH + 1);

  initial begin
    if (LINE_DEPTH <= MAX_DELAY || MAX_DELAY < 1) begin
      $error("LINE_DEPTH must exceed MAX_DELAY");
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  // Q15 scaling of a headroom word
  function automatic logic signed [ACC_W-1:0] scale(
    input logic signed [ACC_W-1:0] x, input logic [16:0] g);
    logic signed [ACC_W+17:0] p;
    p = x * $signed({1'b0, g});
    return ACC_W'(p >>> GAIN_FRAC);
  endfunction

  // Clip a headroom word into the audio word
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [ACC_W-1:0] x);
    logic signed [ACC_W-1:0] hi;
    hi = ACC_W'((1 << (SAMPLE_W - 1)) - 1);
    if (x > hi) return SAMPLE_W'(hi);
    if (x < -hi - 1) return SAMPLE_W'(-hi - 1);
    return SAMPLE_W'(x);
  endfunction

  // Balance gain: full on the favoured side, falling to zero on the other
  function automatic logic [16:0] bal_gain(input logic signed [16:0] bal, input logic right);
    if (right) return (bal < 0) ? 17'(GAIN_FULL + bal) : GAIN_FULL;
    return (bal > 0) ? 17'(GAIN_FULL - bal) : GAIN_FULL;
  endfunction

  // Effective delay in samples, rounded to nearest and capped
  function automatic logic [AW-1:0] delay_samples(
    input tap_delay_type d, input logic [9:0] mult);
    logic signed [31:0] units;
    logic [31:0] prod;
    logic [31:0] smp;
    units = 32'(d.coarse) * FINE_PER_COARSE + 32'(d.fine);
    if (units < 0) units = 0;
    prod = 32'(units) * 32'(mult) * DLY_NUM;
    smp = (prod + DLY_DEN / 2) / DLY_DEN;
    if (smp > 32'(MAX_DELAY)) smp = 32'(MAX_DELAY);
    if (smp < 1) smp = 1;
    return AW'(smp);
  endfunction

  // Clamp a signed 17-bit balance write to +/- full scale
  function automatic logic signed [16:0] clamp_bal(input logic [31:0] w);
    logic signed [31:0] v;
    v = $signed(w);
    if (v > 32'sd32768) return 17'sh0_8000;
    if (v < -32'sd32768) return -17'sh0_8000;
    return 17'(v);
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic hold;                        // Freeze delay contents
  logic [16:0] feedback;             // Loop tap return level
  logic [16:0] treble_rolloff_corner;  // Lowpass coefficient
  logic [16:0] wet;                  // Wet/dry mix
  logic signed [16:0] dry_bal;       // Dry path balance
  logic [15:0] out_gain;             // Output gain, 0 mutes
  logic [9:0] length_multiplier;     // Common delay multiplier
  tap_delay_type tap_delay [TAP_COUNT];  // Index 0 is the loop tap
  logic [16:0] tap_level [TAP_COUNT-1];
  logic signed [16:0] tap_bal [TAP_COUNT-1];
  logic [AW-1:0] dly [TAP_COUNT];    // Computed delays in samples
  logic apb_wr;
  logic [4:0] widx;                  // Word index within the map
  logic hit;
  logic [31:0] rd_mux;
  state_type state;
  logic [FCW-1:0] fifo_count;

  assign apb_wr = psel && penable && pwrite;
  assign widx = paddr[6:2];
  assign pready = 1'b1;  // Zero wait state slave

  // Software writes; every setting is shared by both channels, the balances weighting left against right
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
      feedback <= RST_FEEDBACK;
      treble_rolloff_corner <= RST_TREBLE;
      wet <= RST_WET;
      dry_bal <= '0;
      out_gain <= RST_OUT_GAIN;
      length_multiplier <= RST_LENGTH_MULT;
      for (int i = 0; i < TAP_COUNT; i++) begin
        tap_delay[i] <= '0;
      end
      for (int i = 0; i < TAP_COUNT - 1; i++) begin
        tap_level[i] <= RST_LEVEL;
        tap_bal[i] <= '0;
      end
    end else if (apb_wr && paddr[1:0] == 2'b00) begin
      // Levels saturate at unity; only out_gain is stored unclipped and can exceed full scale
      if (paddr == OFS_CONTROL) hold <= pwdata[0];
      if (paddr == OFS_FEEDBACK) feedback <= (pwdata > 32'(GAIN_FULL)) ? GAIN_FULL : pwdata[16:0];
      if (paddr == OFS_TREBLE) begin
        treble_rolloff_corner <= (pwdata > 32'(GAIN_FULL)) ? GAIN_FULL : pwdata[16:0];
      end
      if (paddr == OFS_WET) wet <= (pwdata > 32'(GAIN_FULL)) ? GAIN_FULL : pwdata[16:0];
      if (paddr == OFS_DRY_BAL) dry_bal <= clamp_bal(pwdata);
      if (paddr == OFS_OUT_GAIN) out_gain <= pwdata[15:0];
      if (paddr == OFS_LENGTH_MULT) begin
        length_multiplier <= (pwdata > MULT_MAX) ? 10'(MULT_MAX) : pwdata[9:0];
      end
      for (int i = 0; i < TAP_COUNT; i++) begin
        if (paddr == OFS_TAP_DELAY + 8'(4 * i)) begin
          tap_delay[i].coarse <= (pwdata[6:0] > 7'(COARSE_MAX)) ? 7'(COARSE_MAX) : pwdata[6:0];
          if ($signed(pwdata[15:8]) > 8'sd100) tap_delay[i].fine <= 8'(FINE_LIMIT);
          else if ($signed(pwdata[15:8]) < -8'sd100) tap_delay[i].fine <= -8'(FINE_LIMIT);
          else tap_delay[i].fine <= pwdata[15:8];
        end
      end
      for (int i = 0; i < TAP_COUNT - 1; i++) begin
        if (paddr == OFS_TAP_LEVEL + 8'(4 * i)) begin
          tap_level[i] <= (pwdata > 32'(GAIN_FULL)) ? GAIN_FULL : pwdata[16:0];
        end
        if (paddr == OFS_TAP_BAL + 8'(4 * i)) tap_bal[i] <= clamp_bal(pwdata);
      end
    end
  end

  // Delay lengths follow the settings one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < TAP_COUNT; i++) dly[i] <= AW'(1);
    end else begin
      for (int i = 0; i < TAP_COUNT; i++) begin
        dly[i] <= delay_samples(tap_delay[i], length_multiplier);
      end
    end
  end

  // Read decode; unmapped or misaligned addresses answer with an error
  always_comb begin
    hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS)
          && !(paddr > OFS_LENGTH_MULT && paddr < OFS_TAP_DELAY)
          && !(paddr > OFS_TAP_DELAY + 8'h10 && paddr < OFS_TAP_LEVEL);
    rd_mux = '0;
    unique case (paddr)
      OFS_CONTROL: rd_mux = {31'h0, hold};
      OFS_FEEDBACK: rd_mux = 32'(feedback);
      OFS_TREBLE: rd_mux = 32'(treble_rolloff_corner);
      OFS_WET: rd_mux = 32'(wet);
      OFS_DRY_BAL: rd_mux = 32'(dry_bal);
      OFS_OUT_GAIN: rd_mux = 32'(out_gain);
      OFS_LENGTH_MULT: rd_mux = 32'(length_multiplier);
      OFS_STATUS: rd_mux = {16'h0, 8'(fifo_count), 5'h0, state};
      default: begin
        for (int i = 0; i < TAP_COUNT; i++) begin
          if (widx == 5'(8 + i)) rd_mux = 32'({tap_delay[i].fine, 1'b0, tap_delay[i].coarse});
          if (widx == 5'(24 + i)) rd_mux = 32'(dly[i]);
        end
        for (int i = 0; i < TAP_COUNT - 1; i++) begin
          if (widx == 5'(16 + i)) rd_mux = 32'(tap_level[i]);
          if (widx == 5'(20 + i)) rd_mux = 32'(tap_bal[i]);
        end
      end
    endcase
  end

  // Read data is captured in the setup phase so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !hit || (paddr >= OFS_TAP_SAMPLES && pwrite);
    end
  end

  // ----------------------------------------------------------------
  // Delay line and per-sample sequencer
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0] line_l [LINE_DEPTH];  // Left delay memory
  logic signed [SAMPLE_W-1:0] line_r [LINE_DEPTH];  // Right delay memory
  logic [AW-1:0] wp;                 // Write pointer
  logic [2:0] tap_sel;               // Tap being read
  logic [AW-1:0] rd_idx;
  stereo_type in_hold;               // Captured input sample
  stereo_type loop_s;                // Loop tap sample
  stereo_type result;                // Mixed output sample
  logic signed [ACC_W-1:0] acc_l;    // Wet sum, left
  logic signed [ACC_W-1:0] acc_r;    // Wet sum, right
  logic signed [ACC_W-1:0] lp_l;     // Lowpass state, left
  logic signed [ACC_W-1:0] lp_r;     // Lowpass state, right
  logic signed [ACC_W-1:0] next_lp_l;
  logic signed [ACC_W-1:0] next_lp_r;
  logic signed [ACC_W-1:0] tl;
  logic signed [ACC_W-1:0] tr;
  logic signed [ACC_W-1:0] mix_l;
  logic signed [ACC_W-1:0] mix_r;
  logic [16:0] fb;
  logic [1:0] k;
  logic fifo_in_ready;

  assign in_ready = (state == ST_IDLE);
  assign k = 2'(tap_sel - 3'd1);

  // Read index wraps behind the write pointer
  always_comb begin
    rd_idx = (wp >= dly[tap_sel]) ? AW'(wp - dly[tap_sel])
                                  : AW'(wp + AW'(LINE_DEPTH) - dly[tap_sel]);
  end

  // Tap path: level stage first, then balance stage
  always_comb begin
    tl = scale(ACC_W'(line_l[rd_idx]), tap_level[k]);
    tr = scale(ACC_W'(line_r[rd_idx]), tap_level[k]);
    tl = scale(tl, bal_gain(tap_bal[k], 1'b0));
    tr = scale(tr, bal_gain(tap_bal[k], 1'b1));
  end

  // Delay input: loop tap only is returned, hold mutes input
  always_comb begin
    fb = hold ? GAIN_FULL : feedback;
    next_lp_l = scale(ACC_W'(loop_s.left), fb);
    next_lp_r = scale(ACC_W'(loop_s.right), fb);
    if (!hold) begin
      next_lp_l = next_lp_l + ACC_W'(in_hold.left);
      next_lp_r = next_lp_r + ACC_W'(in_hold.right);
    end
    // One pole: y += c * (x - y); coefficient unity means no treble loss
    next_lp_l = lp_l + scale(next_lp_l - lp_l, treble_rolloff_corner);
    next_lp_r = lp_r + scale(next_lp_r - lp_r, treble_rolloff_corner);
  end

  // Dry balance, wet/dry crossfade and output gain
  always_comb begin
    mix_l = scale(scale(ACC_W'(in_hold.left), bal_gain(dry_bal, 1'b0)),
                  17'(GAIN_FULL - wet)) + scale(acc_l, wet);
    mix_r = scale(scale(ACC_W'(in_hold.right), bal_gain(dry_bal, 1'b1)),
                  17'(GAIN_FULL - wet)) + scale(acc_r, wet);
    // Product is widened first; a headroom-wide product would wrap before the shift
    mix_l = ACC_W'(((ACC_W + 18)'(mix_l) * (ACC_W + 18)'($signed({1'b0, out_gain})))
                   >>> OUT_GAIN_FRAC);
    mix_r = ACC_W'(((ACC_W + 18)'(mix_r) * (ACC_W + 18)'($signed({1'b0, out_gain})))
                   >>> OUT_GAIN_FRAC);
  end

  // Sequencer: clear memory once, then per sample read taps, write, push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CLEAR;
      wp <= '0;
      tap_sel <= '0;
      in_hold <= '0;
      loop_s <= '0;
      result <= '0;
      acc_l <= '0;
      acc_r <= '0;
      lp_l <= '0;
      lp_r <= '0;
    end else begin
      unique case (state)
        ST_CLEAR: begin
          // Wipes stale memory so first echoes are silence
          wp <= (wp == AW'(LINE_DEPTH - 1)) ? '0 : wp + 1'b1;
          if (wp == AW'(LINE_DEPTH - 1)) state <= ST_IDLE;
        end
        ST_IDLE: begin
          if (in_valid) begin
            in_hold <= in_sample;
            tap_sel <= '0;
            acc_l <= '0;
            acc_r <= '0;
            state <= ST_TAPS;
          end
        end
        ST_TAPS: begin
          if (tap_sel == 3'd0) begin
            loop_s <= '{left: line_l[rd_idx], right: line_r[rd_idx]};
          end else begin
            acc_l <= acc_l + tl;
            acc_r <= acc_r + tr;
          end
          tap_sel <= tap_sel + 3'd1;
          if (tap_sel == 3'(TAP_COUNT - 1)) state <= ST_WRITE;
        end
        ST_WRITE: begin
          lp_l <= next_lp_l;
          lp_r <= next_lp_r;
          wp <= (wp == AW'(LINE_DEPTH - 1)) ? '0 : wp + 1'b1;
          result <= '{left: sat(mix_l), right: sat(mix_r)};
          state <= ST_PUSH;
        end
        ST_PUSH: begin
          // A full FIFO stalls here, and in_ready stays low meanwhile
          if (fifo_in_ready) state <= ST_IDLE;
        end
        default: state <= ST_CLEAR;
      endcase
    end
  end

  // Delay memory writes
  always_ff @(posedge pclk) begin
    if (state == ST_CLEAR) begin
      line_l[wp] <= '0;
      line_r[wp] <= '0;
    end else if (state == ST_WRITE) begin
      line_l[wp] <= sat(next_lp_l);
      line_r[wp] <= sat(next_lp_r);
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  delay_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) out_fifo (
    .clk(pclk),
    .resetn(presetn),
    .in_valid(state == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(result),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_sample),
    .count(fifo_count)
  );
endmodule

`default_nettype wire

// *** design/stereo_four_tap_delay_pkg.sv ***
/*
  Shared constants, register map and carrier types of the stereo four tap delay.
  Assumes a 100 MHz APB clock and an audio stream at 48 kHz sample rate.
*/
package stereo_four_tap_delay_pkg;
  // ----------------------------------------------------------------
  // Audio format and timing
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 24;            // Audio word width
  localparam int ACC_W = 28;               // Internal headroom width
  localparam int CLK_HZ = 100000000;       // APB clock rate
  localparam int SAMPLE_RATE_HZ = 48000;   // Audio sample rate
  localparam int SAMPLE_PERIOD_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int MAX_DELAY_MS = 2550;      // Longest tap delay
  localparam int MAX_DELAY_SAMPLES = MAX_DELAY_MS * SAMPLE_RATE_HZ / 1000;
  // ----------------------------------------------------------------
  // Delay setting arithmetic
  // ----------------------------------------------------------------
  localparam int TAP_COUNT = 5;            // Loop tap plus four output taps
  localparam int COARSE_STEP_US = 20000;   // Coarse step, 20 ms
  localparam int FINE_STEP_US = 200;       // Fine step, 0.2 ms
  localparam int FINE_PER_COARSE = COARSE_STEP_US / FINE_STEP_US;
  localparam int COARSE_MAX = 127;         // 2540 ms
  localparam int FINE_LIMIT = 100;         // +/-20 ms
  localparam int MULT_UNITY = 100;         // Multiplier code of 1.00x
  localparam int MULT_MAX = 1000;          // Multiplier code of 10.00x
  localparam int DLY_NUM = FINE_STEP_US * SAMPLE_RATE_HZ / 100000;
  localparam int DLY_DEN = MULT_UNITY * (1000000 / 100000);
  // ----------------------------------------------------------------
  // Gains: Q15 with unity as 32768, output gain Q4.12
  // ----------------------------------------------------------------
  localparam logic [16:0] GAIN_FULL = 17'h0_8000;
  localparam int GAIN_FRAC = 15;
  localparam int OUT_GAIN_FRAC = 12;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FEEDBACK = 8'h04;
  localparam logic [7:0] OFS_TREBLE = 8'h08;
  localparam logic [7:0] OFS_WET = 8'h0C;
  localparam logic [7:0] OFS_DRY_BAL = 8'h10;
  localparam logic [7:0] OFS_OUT_GAIN = 8'h14;
  localparam logic [7:0] OFS_LENGTH_MULT = 8'h18;
  localparam logic [7:0] OFS_TAP_DELAY = 8'h20;  // Five words, loop tap first
  localparam logic [7:0] OFS_TAP_LEVEL = 8'h40;  // Four words
  localparam logic [7:0] OFS_TAP_BAL = 8'h50;    // Four words
  localparam logic [7:0] OFS_TAP_SAMPLES = 8'h60; // Five read-only words
  localparam logic [7:0] OFS_STATUS = 8'h74;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [16:0] RST_FEEDBACK = 17'h0_0000;
  localparam logic [16:0] RST_TREBLE = 17'h0_8000;   // No treble loss
  localparam logic [16:0] RST_WET = 17'h0_4000;
  localparam logic [16:0] RST_LEVEL = 17'h0_8000;
  localparam logic [15:0] RST_OUT_GAIN = 16'h1000;   // Unity
  localparam logic [9:0] RST_LENGTH_MULT = 10'h064;  // 1.00x
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } stereo_type;
  typedef struct packed {
    logic signed [7:0] fine;   // 0.2 ms steps
    logic [6:0] coarse;        // 20 ms steps
  } tap_delay_type;
  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_IDLE = 3'b001,
    ST_TAPS = 3'b010,
    ST_WRITE = 3'b011,
    ST_PUSH = 3'b100
  } state_type;
endpackage

// *** verification/delay_props.sv ***
/*
  Port checker for the stereo four tap delay: APB answers and stream pacing.
  Assumes one clock pclk and the asynchronous active-low reset presetn.
*/
`timescale 1ns/1ps
`default_nettype none
module delay_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire stereo_four_tap_delay_pkg::stereo_type out_sample
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Sample accepted, and APB access phase
  sequence s_take; in_valid && in_ready; endsequence
  sequence s_acc; psel && penable; endsequence
  property p_gap; s_take |=> !in_ready [*7]; endproperty
  property p_first; (in_valid && in_ready && !out_valid) |-> ##8 out_valid; endproperty
  property p_quiet; (in_valid && in_ready && !out_valid) |=> !out_valid [*7]; endproperty
  property p_keep; out_valid && !out_ready |=> out_valid && $stable(out_sample); endproperty
  property p_ro; s_acc and pwrite && paddr == 8'h60 |-> pslverr; endproperty
  property p_map; s_acc and paddr == 8'h04 |-> !pslverr; endproperty
  property p_hole; s_acc and paddr == 8'h1C |-> pslverr && prdata == 32'h0; endproperty
  property p_ready; s_acc |-> pready && (!pwrite || prdata == 32'h0); endproperty
  a_gap: assert property (p_gap) else $error("input taken too soon");
  a_first: assert property (p_first) else $error("result late or early");
  a_quiet: assert property (p_quiet) else $error("output before result");
  a_keep: assert property (p_keep) else $error("output word dropped");
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  a_map: assert property (p_map) else $error("mapped word refused");
  a_hole: assert property (p_hole) else $error("hole not refused");
  a_ready: assert property (p_ready) else $error("access stalled");
endmodule
bind stereo_four_tap_delay delay_props delay_props_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .in_valid, .in_ready, .out_valid,
  .out_ready, .out_sample);
`default_nettype wire

// *** verification/stream_sink.sv ***
/*
  Downstream sink model: records every stereo word it takes.
  Assumes the bench steers stall; ready follows it one edge late, like a real sink.
*/
`timescale 1ns/1ps
`default_nettype none
module stream_sink
  import stereo_four_tap_delay_pkg::*;
(
  input wire logic pclk,
  input wire logic stall,
  input wire logic out_valid,
  input wire stereo_four_tap_delay_pkg::stereo_type out_sample,
  output logic out_ready
);
  stereo_type got [0:63];  // Words in arrival order
  int n_got = 0;           // Words taken so far
  initial out_ready = 1'b0;
  // Take a word whenever both sides agree
  always @(posedge pclk) begin
    out_ready <= !stall;
    if (out_valid && out_ready) begin
      got[n_got % 64] <= out_sample;
      n_got <= n_got + 1;
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
/*
  Self-checking bench of the stereo four tap delay, short delay memory.
  Assumes the package, the design, the checker and the sink model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, x, g); end end
module testbench;
  import stereo_four_tap_delay_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, stall = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, in_ready, out_valid, out_ready, e;
  stereo_type in_sample = '0, out_sample, v;
  int n_errors = 0, total_checks = 0, seen = 0, j;
  always #5 pclk = ~pclk;
  // Short memory keeps the clearing pass brief
  stereo_four_tap_delay #(.MAX_DELAY(200), .LINE_DEPTH(256)) stereo_four_tap_delay_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_ready, .in_sample, .out_valid, .out_ready, .out_sample);
  stream_sink stream_sink_i (.pclk, .stall, .out_valid, .out_sample, .out_ready);
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic stuck;
    n_errors++;
    $display("BAD wait exp done got timeout");
    conclude();
  endtask
  // One APB transfer; waits up to 50 cycles for pready, then ends the run as stuck
  task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w[0]; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (!pready && k < 50);
    if (!pready) stuck();
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic put(input stereo_type s);
    int k;
    @(posedge pclk);
    in_valid <= 1'b1; in_sample <= s;
    k = 0;
    do begin @(posedge pclk); k++; end while (!in_ready && k < 500);
    if (!in_ready) stuck();
    in_valid <= 1'b0;
  endtask
  task automatic take;
    for (int k = 0; k < 500 && stream_sink_i.n_got <= seen; k++) @(posedge pclk);
    if (stream_sink_i.n_got <= seen) stuck();
    v = stream_sink_i.got[seen];
    seen++;
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h04, 8'h0C, 8'h18, 8'h14, 8'h40};
    logic [31:0] x [5] = '{32'h0, 32'h4000, 32'h64, 32'h1000, 32'h8000};
    for (int i = 0; i < 5; i++) begin
      apb(0, a[i], 0);
      `CHK("reset value", x[i], q)
    end
    apb(0, 8'h1C, 0);
    `CHK("hole error", 1'b1, e)
    apb(1, 8'h60, 1);
    `CHK("read-only error", 1'b1, e)
    $display("t_regs done");
  endtask
  task automatic t_len;
    logic [15:0] d [6] = '{16'h0A00, 16'h0100, 16'h0001, 16'h0A00, 16'h0001, 16'h0100};
    logic [31:0] m [6] = '{100, 100, 100, 50, 10, 100};
    logic [31:0] s [6] = '{96, 10, 200, 48, 96, 10};
    for (int i = 0; i < 6; i++) begin
      apb(1, 8'h24, {16'h0, d[i]});
      apb(1, 8'h18, m[i]);
      apb(0, 8'h64, 0);
      `CHK("tap samples", s[i], q)
    end
    $display("t_len done");
  endtask
  task automatic t_dry;
    logic [31:0] b [5] = '{0, 32'h8000, 32'hFFFF_8000, 0, 0};
    logic [31:0] g [5] = '{32'h1000, 32'h1000, 32'h1000, 32'h2000, 0};
    logic [23:0] l [5] = '{24'h01_0000, 24'h0, 24'h01_0000, 24'h02_0000, 24'h0};
    logic [23:0] r [5] = '{24'h02_0000, 24'h02_0000, 24'h0, 24'h04_0000, 24'h0};
    apb(1, 8'h0C, 0);
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h10, b[i]);
      apb(1, 8'h14, g[i]);
      put({24'h01_0000, 24'h02_0000});
      take();
      `CHK("dry left", l[i], v.left)
      `CHK("dry right", r[i], v.right)
    end
    apb(1, 8'h10, 0);
    apb(1, 8'h14, 32'h1000);
    $display("t_dry done");
  endtask
  // Sink stalls: the buffer fills, input is refused, order is kept
  task automatic t_fill;
    stall <= 1'b1;
    for (j = 0; j < 9; j++) put({j[23:0] + 24'h1, j[23:0]});
    repeat (20) @(posedge pclk);
    `CHK("busy while full", 1'b0, in_ready)
    apb(0, 8'h74, 0);
    `CHK("fifo count", 8'h08, q[15:8])
    stall <= 1'b0;
    for (j = 0; j < 9; j++) begin
      take();
      `CHK("fifo order", {j[23:0] + 24'h1, j[23:0]}, v)
    end
    $display("t_fill done");
  endtask
  // Tap 1 ten samples late, left only; other taps silenced
  task automatic t_wet;
    apb(1, 8'h0C, 32'h8000);
    for (j = 0; j < 3; j++) apb(1, 8'h44 + j[7:0] * 8'h4, 0);
    apb(1, 8'h50, 32'hFFFF_8000);
    for (j = 0; j < 11; j++) put(j == 0 ? {24'h10_0000, 24'h10_0000} : 48'h0);
    for (j = 0; j < 11; j++) take();
    `CHK("tap left", 24'h10_0000, v.left)
    `CHK("tap right", 24'h0, v.right)
    $display("t_wet done");
  endtask
  // Hold with loop and tap 1 both ten samples: input shut out, loop returns at unity
  task automatic t_hold;
    apb(1, 8'h20, 32'h0100);
    apb(1, 8'h50, 0);
    put({24'h10_0000, 24'h08_0000});
    take();
    apb(1, 8'h00, 1);
    for (j = 1; j <= 20; j++) begin
      put({24'h20_0000, 24'h20_0000});
      take();
      if (j == 11) `CHK("hold blocks input", 24'h0, v.left)
      if (j == 20) `CHK("hold loop", {24'h10_0000, 24'h08_0000}, v)
    end
    apb(1, 8'h00, 0);
    $display("t_hold done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (j = 0; j < 400 && !in_ready; j++) @(posedge pclk);
    if (!in_ready) stuck();
    t_regs();
    t_len();
    t_dry();
    t_fill();
    t_wet();
    t_hold();
    conclude();
  end
endmodule
`default_nettype wire
